/* File: core/rtc_timer_alarm_cfg.svh */
// Offsets, field positions, reset values and timing counts of the timer block.
// Assumes the includer compiles it once per unit; the guard stops repeats.
`ifndef RTC_TIMER_ALARM_CFG_SVH
`define RTC_TIMER_ALARM_CFG_SVH

// Register offsets on the byte-wide register port
`define RTC_CAPTURE_OFS      8'h00
`define RTC_CTRL_OFS         8'h04
`define RTC_ALARM_OFS        8'h08

// Control register field positions
`define RTC_BIT_OSC_EN       7
`define RTC_BIT_MCLK_EN      6
`define RTC_BIT_OSC_FAIL     5
`define RTC_BIT_RUN          4
`define RTC_BIT_ALARM_EN     3
`define RTC_BIT_ALARM_FLAG   2
`define RTC_BIT_LOAD         1
`define RTC_BIT_SNAP         0

// Reset values
`define RTC_CTRL_RST         8'h00
`define RTC_FAIL_RST         1'b1
`define RTC_TIMER_RST        32'h0000_0000
`define RTC_BYTE_RST         8'h00

// Timing: system clock period and missing-clock timeout
`define RTC_CLK_PERIOD_PS    4000
`define RTC_MISS_TIME_US     100
`define RTC_MISS_CYCLES      ((`RTC_MISS_TIME_US * 1000 * 1000) / `RTC_CLK_PERIOD_PS)

`endif

/* File: core/rtc_pkg.sv */
// Types shared by the timer block and its bench.
// Assumes the constants header is included beside it.
package rtc_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [31:0] count_t;

	// One register-port request, valid in the cycle it is presented
	typedef struct packed
	{
		byte_t addr;
		byte_t wdata;
		logic  wr;
		logic  rd;
	} reg_req_s;

endpackage : rtc_pkg

/* File: core/rtc_timer_alarm.sv */
// Real-time timer with capture buffer, equality alarm and control register.
// Assumes one system clock; the oscillator arrives as an asynchronous pin.
//
// Summary of operation
// - Load or snapshot timer without stopping it
// - Load request copies capture buffer into timer
// - Load request bit self-clears when load done
// - Snapshot request copies timer into capture buffer
// - Snapshot request bit self-clears when copy done
// - Alarm fires only on exact 32-bit equality
// - Auto reset zeroes timer one oscillator cycle after alarm
// - Alarm event offered as output for system use
// - Writing alarm enable zero clears alarm flag
// - Unchanged match re-fires after timer wrap or after auto reset
// - Alarm flag lasts at most one oscillator cycle unless count stays on match
// - Timer wraps to zero and keeps counting
// - Control register layout at offset 0x04
// - Bit 7 switches the oscillator on and off
// - Bit 6 enables the missing-clock detector
// - Fail flag set on timeout, software clears it
// - Run bit increments timer each oscillator cycle
// - Flag position writes auto reset, reads flag
// - Detector times out after 100 us stable
`timescale 1ns/100ps
`include "rtc_timer_alarm_cfg.svh"

module rtc_timer_alarm
#(
	parameter int unsigned MISS_CYCLES = `RTC_MISS_CYCLES
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire rtc_pkg::reg_req_s req_i,
	output logic [7:0]            rd_data_o,
	input  wire logic             rtc_osc_i,
	output logic                  osc_enable_o,
	output logic                  alarm_event_o,
	output logic                  osc_fail_o
);
	import rtc_pkg::*;

	// Counter width covers the parked value one past the limit
	localparam int unsigned MISS_W = $clog2(MISS_CYCLES + 2);

	// True when an address falls in the four-byte group at base
	function automatic logic in_group(input byte_t addr, input byte_t base);
		in_group = (addr[7:2] == base[7:2]);
	endfunction : in_group

	logic              osc_s1_r;
	logic              osc_s2_r;
	logic              osc_s3_r;
	logic              osc_lvl_r;
	logic              osc_change;
	logic              tick;
	logic [MISS_W-1:0] miss_cnt_r;
	logic              miss_timeout;
	logic              osc_en_r;
	logic              mclk_en_r;
	logic              fail_r;
	logic              run_r;
	logic              alarm_en_r;
	logic              auto_reset_r;
	logic              alarm_flag_r;
	logic              load_req_r;
	logic              snap_req_r;
	count_t            timer_r;
	count_t            capture_r;
	count_t            alarm_r;
	logic              wr_ctrl;
	logic              alarm_match;
	byte_t             ctrl_view;
	byte_t             rd_nxt;
	byte_t             rd_data_r;

	// Oscillator pin synchroniser
	// First stage may go metastable; only the second reads it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else
		begin
			osc_s1_r <= rtc_osc_i;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// Settled level changes only when the last two stages agree
	assign osc_change = (osc_s2_r == osc_s3_r) && (osc_s3_r != osc_lvl_r);
	assign tick       = osc_change && osc_s3_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_lvl_r <= 1'b0;
		end
		else if (osc_change)
		begin
			osc_lvl_r <= osc_s3_r;
		end
	end

	// Missing-clock detector: one-shot after the level stands too long
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			miss_cnt_r <= '0;
		end
		else if (!mclk_en_r || osc_change)
		begin
			miss_cnt_r <= '0;
		end
		else if (miss_cnt_r != MISS_W'(MISS_CYCLES + 1))
		begin
			miss_cnt_r <= miss_cnt_r + 1'b1;
		end
	end

	// One-shot: the counter parks one past the limit
	assign miss_timeout = mclk_en_r && !osc_change
		&& (miss_cnt_r == MISS_W'(MISS_CYCLES));

	// Control byte decode; one address, no lanes
	assign wr_ctrl = req_i.wr && (req_i.addr == `RTC_CTRL_OFS);

	// Plain control bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_en_r     <= 1'(`RTC_CTRL_RST >> `RTC_BIT_OSC_EN);
			mclk_en_r    <= 1'(`RTC_CTRL_RST >> `RTC_BIT_MCLK_EN);
			run_r        <= 1'(`RTC_CTRL_RST >> `RTC_BIT_RUN);
			alarm_en_r   <= 1'(`RTC_CTRL_RST >> `RTC_BIT_ALARM_EN);
			auto_reset_r <= 1'(`RTC_CTRL_RST >> `RTC_BIT_ALARM_FLAG);
		end
		else if (wr_ctrl)
		begin
			osc_en_r     <= req_i.wdata[`RTC_BIT_OSC_EN];
			mclk_en_r    <= req_i.wdata[`RTC_BIT_MCLK_EN];
			run_r        <= req_i.wdata[`RTC_BIT_RUN];
			alarm_en_r   <= req_i.wdata[`RTC_BIT_ALARM_EN];
			auto_reset_r <= req_i.wdata[`RTC_BIT_ALARM_FLAG];
		end
	end

	// Fail flag: timeout sets, written zero clears, set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fail_r <= `RTC_FAIL_RST;
		end
		else if (miss_timeout)
		begin
			fail_r <= 1'b1;
		end
		else if (wr_ctrl && !req_i.wdata[`RTC_BIT_OSC_FAIL])
		begin
			fail_r <= 1'b0;
		end
	end

	// Load request: software sets, next oscillator tick completes
	// A request stays pending while the oscillator is stopped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			load_req_r <= 1'b0;
		end
		else if (wr_ctrl && req_i.wdata[`RTC_BIT_LOAD])
		begin
			load_req_r <= 1'b1;
		end
		else if (tick)
		begin
			load_req_r <= 1'b0;
		end
	end

	// Snapshot request: software sets, next oscillator tick completes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			snap_req_r <= 1'b0;
		end
		else if (wr_ctrl && req_i.wdata[`RTC_BIT_SNAP])
		begin
			snap_req_r <= 1'b1;
		end
		else if (tick)
		begin
			snap_req_r <= 1'b0;
		end
	end

	// Timer: load beats auto reset beats counting; never halted for access
	// Load and auto reset move only on a tick, in oscillator time
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_r <= `RTC_TIMER_RST;
		end
		else if (tick)
		begin
			if (load_req_r)
			begin
				timer_r <= capture_r;
			end
			else if (alarm_flag_r && auto_reset_r)
			begin
				timer_r <= `RTC_TIMER_RST;
			end
			else if (run_r)
			begin
				timer_r <= timer_r + 32'h0000_0001;
			end
		end
	end

	// Compares the count before the tick lands
	assign alarm_match = alarm_en_r && (timer_r == alarm_r);

	// Alarm flag: each tick recomputes it, so it lasts one oscillator cycle unless the count stays on the match
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			alarm_flag_r <= 1'b0;
		end
		else if (tick)
		begin
			alarm_flag_r <= alarm_match;
		end
		else if (wr_ctrl && !req_i.wdata[`RTC_BIT_ALARM_EN])
		begin
			alarm_flag_r <= 1'b0;
		end
	end

	// Byte-wide capture buffer and match value, low byte at low address
	for (genvar b = 0; b < 4; b++)
	begin : g_bytes
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				capture_r[8*b +: 8] <= `RTC_BYTE_RST;
			end
			else if (tick && snap_req_r)
			begin
				capture_r[8*b +: 8] <= timer_r[8*b +: 8];
			end
			else if (req_i.wr && in_group(req_i.addr, `RTC_CAPTURE_OFS)
				&& (req_i.addr[1:0] == 2'(b)))
			begin
				capture_r[8*b +: 8] <= req_i.wdata;
			end
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				alarm_r[8*b +: 8] <= `RTC_BYTE_RST;
			end
			else if (req_i.wr && in_group(req_i.addr, `RTC_ALARM_OFS)
				&& (req_i.addr[1:0] == 2'(b)))
			begin
				alarm_r[8*b +: 8] <= req_i.wdata;
			end
		end
	end

	// Control read view: flag position shows the event, not auto reset
	always_comb
	begin
		ctrl_view                      = 8'h00;
		ctrl_view[`RTC_BIT_OSC_EN]     = osc_en_r;
		ctrl_view[`RTC_BIT_MCLK_EN]    = mclk_en_r;
		ctrl_view[`RTC_BIT_OSC_FAIL]   = fail_r;
		ctrl_view[`RTC_BIT_RUN]        = run_r;
		ctrl_view[`RTC_BIT_ALARM_EN]   = alarm_en_r;
		ctrl_view[`RTC_BIT_ALARM_FLAG] = alarm_flag_r;
		ctrl_view[`RTC_BIT_LOAD]       = load_req_r;
		ctrl_view[`RTC_BIT_SNAP]       = snap_req_r;
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_nxt = 8'h00;
		if (in_group(req_i.addr, `RTC_CAPTURE_OFS))
		begin
			rd_nxt = capture_r[8*req_i.addr[1:0] +: 8];
		end
		else if (req_i.addr == `RTC_CTRL_OFS)
		begin
			rd_nxt = ctrl_view;
		end
		else if (in_group(req_i.addr, `RTC_ALARM_OFS))
		begin
			rd_nxt = alarm_r[8*req_i.addr[1:0] +: 8];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rd_data_r <= 8'h00;
		end
		else if (req_i.rd)
		begin
			rd_data_r <= rd_nxt;
		end
		else
		begin
			rd_data_r <= 8'h00;
		end
	end

	// Alarm event is the flag itself; routing lives outside
	assign rd_data_o     = rd_data_r;
	assign osc_enable_o  = osc_en_r;
	assign alarm_event_o = alarm_flag_r;
	assign osc_fail_o    = fail_r;

endmodule : rtc_timer_alarm

/* File: testbench/rtc_timer_alarm_checker.sv */
// Port-level checks for the real-time timer block.
// Assumes it is bound onto rtc_timer_alarm; one clock, synchronous reset.
`timescale 1ns/100ps
`include "rtc_timer_alarm_cfg.svh"
module rtc_timer_alarm_checker
#(
	parameter int unsigned MISS_CYCLES = `RTC_MISS_CYCLES
)
(
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire rtc_pkg::reg_req_s req_i,
	input wire logic [7:0]        rd_data_o,
	input wire logic              rtc_osc_i,
	input wire logic              osc_enable_o,
	input wire logic              alarm_event_o,
	input wire logic              osc_fail_o
);
	import rtc_pkg::*;
	logic ctrl_wr;
	assign ctrl_wr = req_i.wr && (req_i.addr == `RTC_CTRL_OFS);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	rd_idle_a: assert property (!$past(req_i.rd) |-> rd_data_o == 8'h00)
		else $error("read data outside read slot");
	unmapped_rd_a: assert property (req_i.rd && req_i.addr == 8'h20 |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	ctrl_read_a: assert property (ctrl_wr ##1 !ctrl_wr ##1 (req_i.rd && req_i.addr == `RTC_CTRL_OFS)
		|=> rd_data_o[7:6] == $past(req_i.wdata[7:6], 3)
		&& rd_data_o[4:3] == $past(req_i.wdata[4:3], 3))
		else $error("control readback wrong");
	osc_en_a: assert property (ctrl_wr |=> osc_enable_o == $past(req_i.wdata[7]))
		else $error("oscillator enable not written");
	osc_hold_a: assert property (!$past(ctrl_wr) |-> $stable(osc_enable_o))
		else $error("oscillator enable moved");
	fail_hold_a: assert property ($fell(osc_fail_o) |-> $past(ctrl_wr && !req_i.wdata[5]))
		else $error("fail flag dropped alone");
	alarm_clr_a: assert property (ctrl_wr && !req_i.wdata[3] |-> ##[1:8] !alarm_event_o)
		else $error("alarm flag not cleared");
	reset_val_a: assert property ($fell(rst_i) |-> osc_fail_o && !osc_enable_o
		&& !alarm_event_o && rd_data_o == 8'h00)
		else $error("reset values wrong");
endmodule : rtc_timer_alarm_checker

/* File: testbench/tb.sv */
// Directed bench for the timer block through its register port.
// Assumes package and header compiled first; the bench drives the oscillator pin.
`timescale 1ns/100ps
`include "rtc_timer_alarm_cfg.svh"
module tb;
	import rtc_pkg::*;
	logic       clk_i;
	logic       rst_i;
	reg_req_s   req;
	logic       osc;
	logic [7:0] rd_data;
	logic       osc_en;
	logic       alarm;
	logic       fail;
	int         err_count;
	int         checks;
	int         alarms;
	count_t     match_v;
	rtc_timer_alarm #(.MISS_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.rd_data_o(rd_data), .rtc_osc_i(osc), .osc_enable_o(osc_en),
		.alarm_event_o(alarm), .osc_fail_o(fail));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input byte_t a, input byte_t d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_i);
		req.wr <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input byte_t a, input byte_t e);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_i);
		req.rd <= 1'b0;
		@(negedge clk_i);
		chk(rd_data, e);
		@(posedge clk_i);
	endtask : rd
	task automatic wr32(input byte_t a, input count_t v);
		for (int i = 0; i < 4; i++)
			wr(a + 8'(i), v[8*i +: 8]);
	endtask : wr32
	task automatic rd32(input byte_t a, input count_t v);
		for (int i = 0; i < 4; i++)
			rd(a + 8'(i), v[8*i +: 8]);
	endtask : rd32
	// Oscillator periods of eight system clocks
	task automatic tick(input int n);
		repeat (n)
		begin
			osc <= 1'b1;
			repeat (4) @(posedge clk_i);
			osc <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask : tick
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial
	begin
		#20000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end
	initial
	begin
		req = '0;
		osc = 1'b0;
		rst_i = 1'b1;
		err_count = 0;
		checks = 0;
		alarms = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`RTC_CTRL_OFS, 8'h20);
		rd(8'h20, 8'h00);
		$display("reset test done");
		wr(`RTC_CTRL_OFS, 8'hC0);
		rd(`RTC_CTRL_OFS, 8'hC0);
		chk({7'h00, osc_en}, 8'h01);
		repeat (30) @(posedge clk_i);
		rd(`RTC_CTRL_OFS, 8'hE0);
		chk({7'h00, fail}, 8'h01);
		wr(`RTC_CTRL_OFS, 8'h80);
		rd(`RTC_CTRL_OFS, 8'h80);
		$display("control test done");
		wr32(`RTC_CAPTURE_OFS, 32'hFFFF_FFFE);
		wr(`RTC_CTRL_OFS, 8'h92);
		rd(`RTC_CTRL_OFS, 8'h92);
		tick(1);
		rd(`RTC_CTRL_OFS, 8'h90);
		wr(`RTC_CTRL_OFS, 8'h91);
		tick(1);
		rd(`RTC_CTRL_OFS, 8'h90);
		rd32(`RTC_CAPTURE_OFS, 32'hFFFF_FFFE);
		tick(1);
		wr(`RTC_CTRL_OFS, 8'h91);
		tick(1);
		rd32(`RTC_CAPTURE_OFS, 32'h0000_0000);
		$display("load and snapshot test done");
		wr(`RTC_CTRL_OFS, 8'h90);
		match_v = 32'hFFFF_FFFF + 32'h0000_0004;
		wr32(`RTC_ALARM_OFS, match_v);
		wr(`RTC_CTRL_OFS, 8'h98);
		tick(2);
		rd(`RTC_CTRL_OFS, 8'h98);
		tick(1);
		rd(`RTC_CTRL_OFS, 8'h9C);
		chk({7'h00, alarm}, 8'h01);
		wr(`RTC_CTRL_OFS, 8'h90);
		rd(`RTC_CTRL_OFS, 8'h90);
		wr(`RTC_CTRL_OFS, 8'h98);
		tick(1);
		rd(`RTC_CTRL_OFS, 8'h98);
		wr(`RTC_CTRL_OFS, 8'h90);
		wr32(`RTC_ALARM_OFS, 32'h0000_0007);
		wr(`RTC_CTRL_OFS, 8'h9C);
		tick(3);
		rd(`RTC_CTRL_OFS, 8'h9C);
		if (alarm === 1'b1)
			alarms++;
		tick(1);
		rd(`RTC_CTRL_OFS, 8'h98);
		wr(`RTC_CTRL_OFS, 8'h9D);
		tick(1);
		rd32(`RTC_CAPTURE_OFS, 32'h0000_0000);
		tick(7);
		if (alarm === 1'b1)
			alarms++;
		chk(8'(alarms), 8'h02);
		$display("alarm test done");
		end_of_test();
	end
endmodule : tb
bind rtc_timer_alarm rtc_timer_alarm_checker #(.MISS_CYCLES(MISS_CYCLES)) checker_i
	(.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rd_data_o(rd_data_o),
	.rtc_osc_i(rtc_osc_i), .osc_enable_o(osc_enable_o),
	.alarm_event_o(alarm_event_o), .osc_fail_o(osc_fail_o));
